// ### src/ust_pkg.sv
// constants, types and framing functions shared by the serial transmitter and receiver
package ust_pkg;

	// register byte offsets (low address byte)
	localparam logic [7:0] OFS_FMT    = 8'h00;
	localparam logic [7:0] OFS_CTRL   = 8'h04;
	localparam logic [7:0] OFS_TXDATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_RXDATA = 8'h10;
	localparam logic [7:0] OFS_CMD    = 8'h14;

	// format / control register fields
	localparam int FMT_PI      = 0;
	localparam int FMT_EPE     = 1;
	localparam int FMT_SBS     = 2;
	localparam int FMT_LEN_LO  = 3;
	localparam int FMT_LEN_HI  = 4;
	localparam int FMT_STROBE  = 5;
	localparam int FMT_MODE    = 6;
	localparam int FMT_W       = 7;
	localparam int CTL_W       = 5;

	// status register fields
	localparam int STS_TX_HOLD_EMPTY = 0;
	localparam int STS_TX_SHIFT_EMPTY = 1;
	localparam int STS_DA   = 2;
	localparam int STS_PE   = 3;
	localparam int STS_FE   = 4;
	localparam int STS_OE   = 5;
	localparam int STS_MODE = 6;

	// command register fields
	localparam int CMD_MRST  = 0;
	localparam int CMD_DACLR = 1;

	// reset values
	localparam logic [FMT_W-1:0] FMT_RST = 7'h00;
	localparam logic [CTL_W-1:0] CTL_RST = 5'h00;

	// bit timing in link clock periods, and the shortest word length in bits
	localparam logic [7:0] BIT_CLKS  = 8'h10;
	localparam logic [7:0] STOP_1    = 8'h10;
	localparam logic [7:0] STOP_15   = 8'h18;
	localparam logic [7:0] STOP_2    = 8'h20;
	localparam logic [3:0] START_CHK = 4'h7;
	localparam logic [3:0] MIN_LEN   = 4'h5;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b001,
		TX_ARMED = 3'b010,
		TX_SHIFT = 3'b100
	} ust_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_START = 3'b010,
		RX_BITS  = 3'b100
	} ust_rx_e;

	// data bits per character
	function automatic logic [3:0] ust_nbits(input logic [CTL_W-1:0] ctl);
		ust_nbits = MIN_LEN + {2'b00, ctl[FMT_LEN_HI], ctl[FMT_LEN_LO]};
	endfunction : ust_nbits

	// keep only the character's low bits
	function automatic logic [7:0] ust_mask(input logic [7:0] d, input logic [CTL_W-1:0] ctl);
		ust_mask = d & (8'hFF >> (4'h8 - ust_nbits(ctl)));
	endfunction : ust_mask

	// expected parity bit
	function automatic logic ust_par(input logic [7:0] d, input logic [CTL_W-1:0] ctl);
		ust_par = ctl[FMT_EPE] ? ^ust_mask(d, ctl) : ~^ust_mask(d, ctl);
	endfunction : ust_par

endpackage : ust_pkg

// ### src/ust_rx.sv
// receiver: start check, sampling, holding register and error flags
`timescale 1ns/100ps
module ust_rx (
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       rx_clock_i,
	input  wire logic                       serial_in_i,
	input  wire logic [ust_pkg::CTL_W-1:0]  ctrl_i,
	input  wire logic                       da_clr_i,
	output logic      [7:0]                 data_o,
	output logic                            da_o,
	output logic                            pe_o,
	output logic                            fe_o,
	output logic                            oe_o
);
	import ust_pkg::*;

	typedef struct packed {
		ust_rx_e    state;
		logic       clk_d;
		logic       sin_d;
		logic [3:0] cnt;
		logic [3:0] idx;
		logic [7:0] shreg;
		logic       par;
		logic [7:0] data;
		logic       da;
		logic       pe;
		logic       fe;
		logic       oe;
	} ust_rx_s;

	localparam ust_rx_s RX_RST = '{state: RX_IDLE, default: '0};

	ust_rx_s st_reg;
	ust_rx_s st_next;
	logic    rise;
	logic    done;
	logic [3:0] cnt_n;

	assign rise  = rx_clock_i & ~st_reg.clk_d;
	assign cnt_n = st_reg.cnt + 4'h1;

	always_comb begin
		st_next = st_reg;
		done = 1'b0;
		st_next.clk_d = rx_clock_i;
		st_next.sin_d = serial_in_i;
		case (st_reg.state)
			RX_IDLE: begin
				if (st_reg.sin_d && !serial_in_i) begin
					st_next.state = RX_START;
					st_next.cnt = 4'h0;
				end
			end
			RX_START: begin
				if (rise) begin
					st_next.cnt = cnt_n;
					if (cnt_n == START_CHK) begin
						st_next.cnt = 4'h0;
						st_next.idx = 4'h0;
						// a high line here was a glitch
						st_next.state = serial_in_i ? RX_IDLE : RX_BITS;
					end
				end
			end
			RX_BITS: begin
				if (rise) begin
					st_next.cnt = cnt_n;
					if (cnt_n == 4'h0) begin
						st_next.idx = st_reg.idx + 4'h1;
						if (st_reg.idx < ust_nbits(ctrl_i)) begin
							st_next.shreg[st_reg.idx[2:0]] = serial_in_i;
						end else if (st_reg.idx == ust_nbits(ctrl_i) && !ctrl_i[FMT_PI]) begin
							st_next.par = serial_in_i;
						end else begin
							done = 1'b1;
							st_next.state = RX_IDLE;
							st_next.data = ust_mask(st_reg.shreg, ctrl_i);
							st_next.oe = st_reg.da;
							st_next.pe = !ctrl_i[FMT_PI] && (st_reg.par != ust_par(st_reg.shreg, ctrl_i));
							st_next.fe = !serial_in_i;
						end
					end
				end
			end
			default: st_next.state = RX_IDLE;
		endcase
		// a new character wins over a clear in the same cycle
		if (done) begin
			st_next.da = 1'b1;
		end else if (da_clr_i) begin
			st_next.da = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg <= RX_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign data_o = st_reg.data;
	assign da_o   = st_reg.da;
	assign pe_o   = st_reg.pe;
	assign fe_o   = st_reg.fe;
	assign oe_o   = st_reg.oe;

	property p_false_start;
		@(posedge core_clk_i) disable iff (rst_i)
		(st_reg.state == RX_START && rise && cnt_n == START_CHK && serial_in_i) |=> st_reg.state == RX_IDLE;
	endproperty
	a_false_start: assert property (p_false_start) else $error("glitch began a character");

	property p_overrun;
		@(posedge core_clk_i) disable iff (rst_i)
		(done && st_reg.da) |=> (oe_o && da_o);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	c_false_start: cover property (@(posedge core_clk_i) disable iff (rst_i)
		st_reg.state == RX_START ##1 st_reg.state == RX_IDLE);
	c_parity_err: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(pe_o));

endmodule : ust_rx

// ### src/ust_top.sv
// serial transmitter with format control, AHB-Lite register slave and receiver
// Operation
// - mode input high selects processor-bus mode
// - receive and transmit run at the same time
// - word length, parity and stop bits programmable
// - brief low glitch never starts reception
// - parity, framing and overrun errors are flagged
// - master reset clears registers, line goes high; the format register keeps its value
// - load strobe captures format inputs into control
// - holding register reports empty after initialisation
// - holding load copies bus, empty flag drops
// - falling edge moves held character to shifter
// - line starts half period later, fixed bit order
// - empty flag rises one period after transfer, on the next falling edge
// - queued character follows last stop without gap
// - both empty flags high when all sent
// - every bit but the half stop bit lasts sixteen transmit clock periods; the half stop bit lasts eight
// - two length selects encode five to eight
// - holding register captures on trailing load edge
// - line idles high, shift empty until start
`timescale 1ns/100ps
module ust_top (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        tx_clock_in_i,
	input  wire logic        rx_clock_in_i,
	input  wire logic        serial_in_i,
	output logic             serial_out_o,
	output logic             tx_hold_empty_o,
	output logic             tx_shift_empty_o,
	output logic             proc_mode_o
);
	import ust_pkg::*;

	typedef struct packed {
		logic [FMT_W-1:0] fmt;
		logic [CTL_W-1:0] ctrl;
		logic             ph_act;
		logic             ph_wr;
		logic [7:0]       ph_addr;
		logic [31:0]      hrdata;
		logic             rdy;
		logic             txc_d;
		logic [7:0]       hold;
		logic             hold_full;
		logic             tx_hold_empty;
		logic             tx_hold_empty_pend;
		ust_tx_e          state;
		logic             queued;
		logic [7:0]       shift;
		logic [CTL_W-1:0] fctl;
		logic [7:0]       cnt;
		logic [7:0]       tot;
		logic             serial_out;
		logic             tx_shift_empty;
	} ust_top_s;

	localparam ust_top_s ST_RST = '{fmt: FMT_RST, ctrl: CTL_RST, rdy: 1'b1, tx_hold_empty: 1'b1,
		state: TX_IDLE, serial_out: 1'b1, tx_shift_empty: 1'b1, default: '0};

	// frame length in transmit clock periods
	function automatic logic [7:0] frame_clks(input logic [CTL_W-1:0] ctl);
		logic [7:0] nb;
		logic [7:0] stop;
		nb = {4'h0, ust_nbits(ctl)} + 8'h1 + {7'h0, ~ctl[FMT_PI]};
		if (!ctl[FMT_SBS]) begin
			stop = STOP_1;
		end else if (ust_nbits(ctl) == MIN_LEN) begin
			stop = STOP_15;
		end else begin
			stop = STOP_2;
		end
		frame_clks = 8'(nb * BIT_CLKS) + stop;
	endfunction : frame_clks

	// line level for bit position idx of a frame
	function automatic logic tx_bit(input logic [7:0] d, input logic [CTL_W-1:0] ctl, input logic [3:0] idx);
		logic [3:0] n;
		n = ust_nbits(ctl);
		if (idx == 4'h0) begin
			tx_bit = 1'b0;
		end else if (idx <= n) begin
			tx_bit = d[3'(idx - 4'h1)];
		end else if (idx == n + 4'h1 && !ctl[FMT_PI]) begin
			tx_bit = ust_par(d, ctl);
		end else begin
			tx_bit = 1'b1;
		end
	endfunction : tx_bit

	ust_top_s   st_reg;
	ust_top_s   st_next;
	logic       tx_rise;
	logic       tx_fall;
	logic       take;
	logic       wr_dp;
	logic       ld;
	logic       mrst;
	logic       da_clr;
	logic       fin;
	logic [7:0] cnt_n;
	logic [7:0] rx_data;
	logic       rx_da;
	logic       rx_pe;
	logic       rx_fe;
	logic       rx_oe;

	assign tx_rise = tx_clock_in_i & ~st_reg.txc_d;
	assign tx_fall = ~tx_clock_in_i & st_reg.txc_d;
	assign take    = hsel_i & hready_i & htrans_i[1];
	assign wr_dp   = st_reg.ph_act & st_reg.ph_wr;
	assign ld      = wr_dp && st_reg.ph_addr == OFS_TXDATA;
	assign mrst    = wr_dp && st_reg.ph_addr == OFS_CMD && hwdata_i[CMD_MRST];
	assign da_clr  = wr_dp && st_reg.ph_addr == OFS_CMD && hwdata_i[CMD_DACLR];
	assign cnt_n   = st_reg.cnt + 8'h1;
	assign fin     = st_reg.state == TX_SHIFT && cnt_n == st_reg.tot;

	// receiver runs concurrently with the transmitter
	ust_rx u_rx (
		.core_clk_i  (core_clk_i),
		.rst_i       (sys_rst_i | mrst),
		.rx_clock_i  (rx_clock_in_i),
		.serial_in_i (serial_in_i),
		.ctrl_i      (st_reg.ctrl),
		.da_clr_i    (da_clr),
		.data_o      (rx_data),
		.da_o        (rx_da),
		.pe_o        (rx_pe),
		.fe_o        (rx_fe),
		.oe_o        (rx_oe)
	);

	always_comb begin
		st_next = st_reg;
		st_next.txc_d = tx_clock_in_i;
		st_next.hrdata = 32'h0000_0000;

		// control follows the format inputs while the strobe is high
		if (st_reg.fmt[FMT_STROBE]) begin
			st_next.ctrl = st_reg.fmt[CTL_W-1:0];
		end
		if (wr_dp && st_reg.ph_addr == OFS_FMT) begin
			st_next.fmt = hwdata_i[FMT_W-1:0];
		end

		// transmit clock falling edge: transfer and empty flag
		if (tx_fall) begin
			if (st_reg.tx_hold_empty_pend) begin
				st_next.tx_hold_empty = 1'b1;
				st_next.hold_full = 1'b0;
				st_next.tx_hold_empty_pend = 1'b0;
			end
			if (st_reg.hold_full && !st_reg.tx_hold_empty_pend && (st_reg.state == TX_IDLE
					|| (st_reg.state == TX_SHIFT && !st_reg.queued && cnt_n == st_reg.tot))) begin
				st_next.shift = st_reg.hold;
				st_next.fctl = st_reg.ctrl;
				st_next.tx_hold_empty_pend = 1'b1;
				if (st_reg.state == TX_IDLE) begin
					st_next.state = TX_ARMED;
				end else begin
					st_next.queued = 1'b1;
				end
			end
		end

		// transmit clock rising edge: drive the line
		if (tx_rise) begin
			case (st_reg.state)
				TX_ARMED: begin
					st_next.state = TX_SHIFT;
					st_next.cnt = 8'h00;
					st_next.serial_out = 1'b0;
					st_next.tx_shift_empty = 1'b0;
					st_next.tot = frame_clks(st_reg.fctl);
				end
				TX_SHIFT: begin
					if (fin && st_reg.queued) begin
						st_next.queued = 1'b0;
						st_next.cnt = 8'h00;
						st_next.serial_out = 1'b0;
						st_next.tot = frame_clks(st_reg.fctl);
					end else if (fin) begin
						st_next.state = TX_IDLE;
						st_next.serial_out = 1'b1;
						st_next.tx_shift_empty = 1'b1;
					end else begin
						st_next.cnt = cnt_n;
						st_next.serial_out = tx_bit(st_reg.shift, st_reg.fctl, cnt_n[7:4]);
					end
				end
				default: begin
					st_next.state = st_reg.state;
				end
			endcase
		end

		// load at the end of the write data phase wins over the transfer
		if (ld) begin
			st_next.hold = hwdata_i[7:0];
			st_next.hold_full = 1'b1;
			st_next.tx_hold_empty = 1'b0;
			st_next.tx_hold_empty_pend = 1'b0;
		end

		if (mrst) begin
			st_next.ctrl = CTL_RST;
			st_next.hold_full = 1'b0;
			st_next.tx_hold_empty = 1'b1;
			st_next.tx_hold_empty_pend = 1'b0;
			st_next.state = TX_IDLE;
			st_next.queued = 1'b0;
			st_next.cnt = 8'h00;
			st_next.serial_out = 1'b1;
			st_next.tx_shift_empty = 1'b1;
		end

		// address phase; reads see this cycle's writes
		st_next.ph_act = take;
		st_next.ph_wr = hwrite_i;
		st_next.ph_addr = haddr_i[7:0];
		if (take && !hwrite_i) begin
			case (haddr_i[7:0])
				OFS_FMT:    st_next.hrdata = {25'h0, st_next.fmt};
				OFS_CTRL:   st_next.hrdata = {27'h0, st_next.ctrl};
				OFS_STATUS: st_next.hrdata = {25'h0, st_next.fmt[FMT_MODE], rx_oe, rx_fe, rx_pe, rx_da,
					st_next.tx_shift_empty, st_next.tx_hold_empty};
				OFS_RXDATA: st_next.hrdata = {24'h0, rx_data};
				default:    st_next.hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_reg <= ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign hrdata_o         = st_reg.hrdata;
	assign hreadyout_o      = st_reg.rdy;
	assign hresp_o          = 1'b0;
	assign serial_out_o     = st_reg.serial_out;
	assign tx_hold_empty_o  = st_reg.tx_hold_empty;
	assign tx_shift_empty_o = st_reg.tx_shift_empty;
	assign proc_mode_o      = st_reg.fmt[FMT_MODE];

	property p_mode;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr_dp && st_reg.ph_addr == OFS_FMT) |=> proc_mode_o == $past(hwdata_i[FMT_MODE]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode select not applied");

	property p_mrst;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		mrst |=> (serial_out_o && tx_hold_empty_o && tx_shift_empty_o && st_reg.ctrl == CTL_RST);
	endproperty
	a_mrst: assert property (p_mrst) else $error("master reset incomplete");

	property p_ctrl_load;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(st_reg.fmt[FMT_STROBE] && !mrst) |=> st_reg.ctrl == $past(st_reg.fmt[CTL_W-1:0]);
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control not loaded by strobe");

	property p_load;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(ld && !mrst) |=> (!tx_hold_empty_o && st_reg.hold == $past(hwdata_i[7:0]));
	endproperty
	a_load: assert property (p_load) else $error("holding load failed");

	property p_xfer;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(st_reg.state == TX_IDLE && st_reg.hold_full && !st_reg.tx_hold_empty_pend && tx_fall && !mrst)
			|=> (st_reg.state == TX_ARMED && st_reg.shift == $past(st_reg.hold));
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer to shifter missed");

	property p_start;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(st_reg.state == TX_ARMED && tx_rise && !mrst) |=> (!serial_out_o && !tx_shift_empty_o);
	endproperty
	a_start: assert property (p_start) else $error("start bit not driven");

	property p_tx_hold_empty_rise;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		($rose(tx_hold_empty_o) && !$past(mrst)) |-> ($past(tx_fall) && $past(st_reg.tx_hold_empty_pend));
	endproperty
	a_tx_hold_empty_rise: assert property (p_tx_hold_empty_rise) else $error("empty flag rose off a falling edge");

	property p_bit_len;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		($changed(serial_out_o) && $past(st_reg.state == TX_SHIFT) && !$past(fin) && !$past(mrst))
			|-> $past(st_reg.cnt[3:0]) == 4'hF;
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("bit cell not sixteen clocks");

	property p_idle;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		tx_shift_empty_o |-> (serial_out_o && st_reg.state != TX_SHIFT);
	endproperty
	a_idle: assert property (p_idle) else $error("line not idle high");

	property p_all_sent;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(fin && tx_rise && !st_reg.queued && !mrst) |=> (tx_shift_empty_o && serial_out_o);
	endproperty
	a_all_sent: assert property (p_all_sent) else $error("shift empty not raised at end");

	property p_queue;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(fin && tx_rise && st_reg.queued && !mrst) |=> (!serial_out_o && !tx_shift_empty_o);
	endproperty
	a_queue: assert property (p_queue) else $error("queued character not started at once");

	property p_empty_flag;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		tx_hold_empty_o == !st_reg.hold_full;
	endproperty
	a_empty_flag: assert property (p_empty_flag) else $error("empty flag wrong for holding register");

	c_back_to_back: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		fin && tx_rise && st_reg.queued);
	c_half_stop: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
		st_reg.state == TX_SHIFT && st_reg.fctl[FMT_SBS] && ust_nbits(st_reg.fctl) == MIN_LEN);
	c_char_sent: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $rose(tx_shift_empty_o));

endmodule : ust_top

// ### bench/ust_term_model.sv
// serial terminal model: frames characters onto the receive line and decodes the transmit line
`timescale 1ns/100ps
module ust_term_model #(
	parameter int BIT_NS = 1600
) (
	input  wire logic line_i,
	output logic      line_o
);
	initial line_o = 1'b1;

	// one frame; parity bit pb only when pen, stop level sv
	task automatic send(input logic [7:0] d, input int nb, input bit pen, input logic pb, input logic sv);
		line_o <= 1'b0;
		#(BIT_NS);
		for (int i = 0; i < nb; i++) begin
			line_o <= d[i];
			#(BIT_NS);
		end
		if (pen) begin
			line_o <= pb;
			#(BIT_NS);
		end
		line_o <= sv;
		#(BIT_NS);
		line_o <= 1'b1;
	endtask : send

	// short low pulse, too short for a start bit
	task automatic glitch(input int ns);
		line_o <= 1'b0;
		#(ns);
		line_o <= 1'b1;
	endtask : glitch

	// decode at mid-bit; t0 is the time of the start edge
	task automatic recv(input int nb, input bit pen, output logic [7:0] d, output logic p,
			output logic s, output realtime t0);
		@(negedge line_i);
		t0 = $realtime;
		d = 8'h00;
		p = 1'b0;
		#(BIT_NS / 2);
		for (int i = 0; i < nb; i++) begin
			#(BIT_NS);
			d[i] = line_i;
		end
		if (pen) begin
			#(BIT_NS);
			p = line_i;
		end
		#(BIT_NS);
		s = line_i;
	endtask : recv
endmodule : ust_term_model

// ### bench/tb_top.sv
// self-checking testbench of the serial transmitter block
`timescale 1ns/100ps
module tb_top;
	import ust_pkg::*;
	logic        core_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
	logic        tclk = 1'b0;
	logic        tdiv = 1'b0;
	logic        ser_in, ser_out, tx_hold_empty, tx_shift_empty, pmode;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	int          failures = 0;
	int          n_checks = 0;

	ust_top i_ust_top (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
		.hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.tx_clock_in_i(tclk),
		.rx_clock_in_i(tclk),
		.serial_in_i(ser_in), .serial_out_o(ser_out), .tx_hold_empty_o(tx_hold_empty), .tx_shift_empty_o(tx_shift_empty),
		.proc_mode_o(pmode));
	ust_term_model #(.BIT_NS(1600)) i_ust_term_model (.line_i(ser_out), .line_o(ser_in));

	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;
	// link clock: 16 ticks per bit, four core cycles per tick
	always @(posedge core_clk) begin
		tdiv <= ~tdiv;
		if (tdiv) begin
			tclk <= ~tclk;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic near(input realtime a, input realtime b);
		near = (a > b - 60.0) && (a < b + 60.0);
	endfunction : near

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= 1'b1;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= 1'b0;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : bus_rd

	task automatic t_reset;
		logic [31:0] v;
		check(ser_out, 1);
		check(tx_hold_empty, 1);
		check(tx_shift_empty, 1);
		check(hreadyout, 1);
		check(hresp, 0);
		bus_rd(OFS_STATUS, v);
		check(v, 32'h3);
		bus_rd(8'h20, v);
		check(v, 32'h0);
		bus_wr(OFS_FMT, 32'h15);
		bus_rd(OFS_CTRL, v);
		check(v, 32'h0);
		bus_wr(OFS_FMT, 32'h75);
		bus_rd(OFS_CTRL, v);
		check(v, 32'h15);
		check(pmode, 1);
		bus_rd(OFS_STATUS, v);
		check(v, 32'h43);
		bus_wr(OFS_FMT, 32'h0A);
		bus_wr(OFS_CTRL, 32'h1F);
		bus_rd(OFS_CTRL, v);
		check(v, 32'h15);
		check(pmode, 0);
	endtask : t_reset

	// every length with inhibit, even and odd parity and all stop settings
	task automatic t_formats;
		logic [7:0] d, m, r;
		logic       p, s;
		realtime    t0, t1;
		int         nb, pm, sb, stc, pen;
		for (int i = 0; i < 12; i++) begin
			nb = 5 + i % 4;
			pm = i / 4;
			sb = (i % 3 != 0);
			pen = (pm != 0);
			stc = (sb == 0) ? 16 : ((nb == 5) ? 24 : 32);
			d = 8'h9B + 8'(i * 37);
			m = d & 8'((1 << nb) - 1);
			bus_wr(OFS_FMT, 32'(32'h20 | (i % 4) * 8 | sb * 4 | (pm == 1) * 2 | (pm == 0)));
			bus_wr(OFS_TXDATA, {24'h000000, d});
			i_ust_term_model.recv(nb, pen[0], r, p, s, t0);
			check(r, m);
			if (pen != 0) check(p, (pm == 1) ? ^m : ~^m);
			check(s, 1);
			@(posedge tx_shift_empty);
			t1 = $realtime;
			check(near(t1 - t0, ((1 + nb + pen) * 16 + stc) * 100.0), 1);
		end
	endtask : t_formats

	task automatic t_b2b;
		logic [7:0] a, b;
		logic       p, s;
		realtime    ta, tb;
		bus_wr(OFS_FMT, 32'h39);
		fork
			begin
				i_ust_term_model.recv(8, 1'b0, a, p, s, ta);
				i_ust_term_model.recv(8, 1'b0, b, p, s, tb);
			end
			begin
				bus_wr(OFS_TXDATA, 32'h3C);
				repeat (2) @(posedge core_clk);
				check(tx_hold_empty, 0);
				wait (tx_hold_empty === 1'b1);
				check(tx_shift_empty, 0);
				bus_wr(OFS_TXDATA, 32'hC3);
				repeat (2) @(posedge core_clk);
				check(tx_hold_empty, 0);
			end
		join
		check(a, 8'h3C);
		check(b, 8'hC3);
		check(near(tb - ta, 16000.0), 1);
		@(posedge tx_shift_empty);
		repeat (2) @(posedge core_clk);
		check(tx_hold_empty, 1);
	endtask : t_b2b

	task automatic t_rx;
		logic [31:0] v;
		logic [7:0]  a;
		logic        p, s;
		realtime     t;
		bus_wr(OFS_FMT, 32'h3A);
		fork
			i_ust_term_model.send(8'h5A, 8, 1'b1, ^8'h5A, 1'b1);
			begin
				bus_wr(OFS_TXDATA, 32'hA7);
				i_ust_term_model.recv(8, 1'b1, a, p, s, t);
			end
		join
		check(a, 8'hA7);
		check(p, ^8'hA7);
		repeat (20) @(posedge core_clk);
		bus_rd(OFS_STATUS, v);
		check(v, 32'h07);
		bus_rd(OFS_RXDATA, v);
		check(v, 32'h5A);
		i_ust_term_model.send(8'h33, 8, 1'b1, ~^8'h33, 1'b0);
		bus_rd(OFS_STATUS, v);
		check(v, 32'h3F);
		bus_wr(OFS_CMD, 32'h2);
		bus_rd(OFS_STATUS, v);
		check(v[2], 0);
		#4800;
		i_ust_term_model.glitch(200);
		#3200;
		bus_rd(OFS_STATUS, v);
		check(v[2], 0);
	endtask : t_rx

	// master reset in the middle of a character
	task automatic t_mreset;
		logic [31:0] v;
		bus_wr(OFS_FMT, 32'h39);
		bus_wr(OFS_FMT, 32'h19);
		bus_wr(OFS_TXDATA, 32'h00);
		wait (ser_out === 1'b0);
		repeat (100) @(posedge core_clk);
		bus_wr(OFS_CMD, 32'h1);
		repeat (2) @(posedge core_clk);
		check(ser_out, 1);
		check(tx_hold_empty, 1);
		bus_rd(OFS_CTRL, v);
		check(v, 32'h0);
		bus_rd(OFS_STATUS, v);
		check(v, 32'h3);
		repeat (200) @(posedge core_clk);
		check(ser_out, 1);
		check(tx_shift_empty, 1);
	endtask : t_mreset

	task automatic summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	initial begin
		sys_rst = 1'b1;
		hsel    = 1'b0;
		haddr   = 32'h0;
		htrans  = 2'b00;
		hwrite  = 1'b0;
		hsize   = 3'b010;
		hwdata  = 32'h0;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_formats();
		t_b2b();
		t_rx();
		t_mreset();
		summarize();
	end

	initial begin
		#2000000;
		failures++;
		summarize();
	end
endmodule : tb_top
